/* File: include/usca_pkg.sv */
// Constants shared by the shadow control alias block and its helpers.
// Assumes a 20 MHz bus clock and a 32-bit AXI4-Lite register bus.
package usca_pkg;
  // Bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] FIFO_CORE_SOFT_RESET_ADDR = 32'h5000_1188;
  localparam logic [ADDR_W-1:0] REQUEST_TO_SEND_ALIAS_ADDR = 32'h5000_118C;
  localparam logic [ADDR_W-1:0] BREAK_CONTROL_ALIAS_ADDR = 32'h5000_1190;
  localparam logic [ADDR_W-1:0] DMA_SIGNAL_MODE_ALIAS_ADDR = 32'h5000_1194;
  localparam logic [ADDR_W-1:0] LINE_OPTIONS_ADDR = 32'h5000_11C0;
  localparam logic [ADDR_W-1:0] ALIAS_STATUS_ADDR = 32'h5000_11C4;

  // Field positions
  localparam int TX_FLUSH_BIT = 2;
  localparam int RX_FLUSH_BIT = 1;
  localparam int SOFT_RESET_BIT = 0;
  localparam int ALIAS_BIT = 0;
  localparam int OPT_FIFO_EN_BIT = 0;
  localparam int OPT_AUTO_FLOW_BIT = 1;
  localparam int OPT_LOOPBACK_BIT = 2;
  localparam int OPT_IR_MODE_BIT = 3;
  localparam int OPT_RX_TRIG_LSB = 4;
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_ABOVE_BIT = 8;
  localparam int STAT_CTRL_RST_BIT = 9;

  // Receive FIFO geometry and trigger selections
  localparam int FIFO_DEPTH = 16;
  localparam int FILL_W = 5;
  localparam logic [1:0] TRIG_ONE_CHAR = 2'h0;
  localparam logic [1:0] TRIG_QUARTER = 2'h1;
  localparam logic [1:0] TRIG_HALF = 2'h2;
  localparam logic [FILL_W-1:0] LEVEL_ONE = 5'h01;
  localparam logic [FILL_W-1:0] LEVEL_QUARTER = 5'h04;
  localparam logic [FILL_W-1:0] LEVEL_HALF = 5'h08;
  localparam logic [FILL_W-1:0] LEVEL_TWO_LESS = 5'h0E;

  // Reset values
  localparam logic ALIAS_RESET = 1'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Infrared break pulsing: period is a longest time, pulse a least time
  localparam int CLK_NS = 50;
  localparam int IR_PERIOD_NS = 8680;
  localparam int IR_PULSE_NS = 1630;
  localparam int IR_CNT_W = 8;
  localparam int IR_PERIOD_CYC = IR_PERIOD_NS / CLK_NS;
  localparam int IR_PULSE_CYC = (IR_PULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* File: rtl/usca_axil.sv */
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the owner decodes addresses combinationally and answers ok flags.
`timescale 1ns/1ns
module usca_axil
  import usca_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Write channels
  input  wire logic [usca_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [usca_pkg::DATA_W-1:0]   wdata,
  input  wire logic [usca_pkg::STRB_W-1:0]   wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // Read channels
  input  wire logic [usca_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [usca_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Register side
  output logic                               wr_en,
  output logic [usca_pkg::ADDR_W-1:0]        wr_addr,
  output logic [usca_pkg::DATA_W-1:0]        wr_data,
  output logic [usca_pkg::STRB_W-1:0]        wr_strb,
  input  wire logic                          wr_ok,
  output logic                               rd_en,
  input  wire logic [usca_pkg::DATA_W-1:0]   rd_data,
  input  wire logic                          rd_ok
);
  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic              awrdy;
    logic              wrdy;
    logic              bvld;
    logic [1:0]        bres;
    logic              arrdy;
    logic              rvld;
    logic [DATA_W-1:0] rdat;
    logic [1:0]        rres;
  } usca_ax_t;

  usca_ax_t st_reg;
  usca_ax_t st_next;

  // Address and data are latched in either order; the write fires once both are held
  always_comb begin
    st_next = st_reg;
    wr_en = 1'b0;
    rd_en = 1'b0;
    if (awvalid && st_reg.awrdy) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && st_reg.wrdy) begin
      st_next.w_got = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end
    if (st_reg.bvld && bready) begin
      st_next.bvld = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvld) begin
      wr_en = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvld = 1'b1;
      st_next.bres = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Readies are registered so they cannot ripple from the bus inputs
    st_next.awrdy = !st_next.aw_got && !st_next.bvld;
    st_next.wrdy = !st_next.w_got && !st_next.bvld;
    if (st_reg.rvld && rready) begin
      st_next.rvld = 1'b0;
    end
    if (arvalid && st_reg.arrdy) begin
      rd_en = 1'b1;
      st_next.rvld = 1'b1;
      st_next.rdat = rd_data;
      st_next.rres = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    st_next.arrdy = !st_next.rvld && !(arvalid && st_reg.arrdy);
    if (rst) begin
      st_next = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // Outputs straight from state
  assign awready = st_reg.awrdy;
  assign wready = st_reg.wrdy;
  assign bvalid = st_reg.bvld;
  assign bresp = st_reg.bres;
  assign arready = st_reg.arrdy;
  assign rvalid = st_reg.rvld;
  assign rdata = st_reg.rdat;
  assign rresp = st_reg.rres;
  assign wr_addr = st_reg.aw_addr;
  assign wr_data = st_reg.w_data;
  assign wr_strb = st_reg.w_strb;
endmodule

/* File: rtl/usca_rst_sync.sv */
// Reset stretcher: asserts at once on its async request, releases on the clock.
// Assumes arst comes from a flip-flop on the same clock, free of glitches.
`timescale 1ns/1ns
module usca_rst_sync (
  // Clock and resets
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic arst,
  // Stretched reset
  output logic      rst_out
);
  typedef struct packed {
    logic [1:0] stg;
  } usca_rs_t;

  usca_rs_t st_reg;
  usca_rs_t st_next;

  // Shift zeros in so the release lands two edges after the request drops
  always_comb begin
    st_next = st_reg;
    st_next.stg = {st_reg.stg[0], 1'b0};
    if (rst) begin
      st_next.stg = '1;
    end
  end

  // Asynchronous set, synchronous release
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rst_out = st_reg.stg[1];
endmodule

/* File: rtl/usca_top.sv */
// Shadow control aliases of a UART controller: flushes, soft reset, line pins.
// Assumes the serial engine and FIFOs sit outside and run on MCLK.
//
// Behaviour
// - Writing one to the transmit flush bit empties the transmit queue pointers.
// - Writing one to the receive flush bit empties the receive queue pointers.
// - Both flush bits clear themselves after one cycle.
// - Soft reset bit asserts controller reset asynchronously, releases it on the clock.
// - Soft reset resets both the bus-side and serial-side logic.
// - Request alias bit is the modem request bit and drives the request pin.
// - Without auto flow and outside loopback, a set request bit drives the active-low pin low.
// - With auto flow and FIFOs on, a reached receive threshold forces request high.
// - In loopback the request pin stays high; the bit loops to the modem input.
// - Break alias bit is the same storage as the line control break bit.
// - Outside loopback a set break holds the transmit line at zero.
// - Outside loopback, in infrared mode a set break pulses the infrared output continuously.
// - In loopback a set break is fed to the receiver, not the line.
// - DMA mode alias bit selects signalling mode zero or one for requests.
// - FIFO enable gates both FIFOs; clearing it resets both FIFO controllers.
// - Receive trigger selects the fill level for interrupts, DMA and auto request.
`timescale 1ns/1ns
module usca_top
  import usca_pkg::*;
(
  // Clock and reset
  input  wire logic                                 MCLK,
  input  wire logic                                 RESET,
  // AXI4-Lite register bus
  input  wire logic [usca_pkg::ADDR_W-1:0]          S_AXI_AWADDR,
  input  wire logic                                 S_AXI_AWVALID,
  output logic                                      S_AXI_AWREADY,
  input  wire logic [usca_pkg::DATA_W-1:0]          S_AXI_WDATA,
  input  wire logic [usca_pkg::STRB_W-1:0]          S_AXI_WSTRB,
  input  wire logic                                 S_AXI_WVALID,
  output logic                                      S_AXI_WREADY,
  output logic [1:0]                                S_AXI_BRESP,
  output logic                                      S_AXI_BVALID,
  input  wire logic                                 S_AXI_BREADY,
  input  wire logic [usca_pkg::ADDR_W-1:0]          S_AXI_ARADDR,
  input  wire logic                                 S_AXI_ARVALID,
  output logic                                      S_AXI_ARREADY,
  output logic [usca_pkg::DATA_W-1:0]               S_AXI_RDATA,
  output logic [1:0]                                S_AXI_RRESP,
  output logic                                      S_AXI_RVALID,
  input  wire logic                                 S_AXI_RREADY,
  // Serial engine and FIFO side
  input  wire logic                                 SER_TXD,
  input  wire logic [usca_pkg::FILL_W-1:0]          RX_FILL_LEVEL,
  output logic                                      TX_FIFO_FLUSH,
  output logic                                      RX_FIFO_FLUSH,
  output logic                                      FIFO_ENABLE,
  output logic [1:0]                                RX_TRIGGER,
  output logic                                      DMA_MODE,
  output logic                                      RX_LINE,
  output logic                                      LOOP_CTS,
  // Controller resets
  output logic                                      CTRL_RESET,
  output logic                                      SER_RESET,
  // Pins
  input  wire logic                                 SIN,
  output logic                                      SOUT,
  output logic                                      RTS_N,
  output logic                                      IR_OUT_N
);
  typedef struct packed {
    logic                rts;
    logic                brk;
    logic                dma_mode;
    logic                fifo_en;
    logic                auto_flow;
    logic                loopback;
    logic                ir_mode;
    logic [1:0]          rx_trig;
    logic                tx_flush;
    logic                rx_flush;
    logic                soft_req;
    logic                sin_meta;
    logic                sin_sync;
    logic                rts_n;
    logic                sout;
    logic                rx_line;
    logic                loop_cts;
    logic                ir_out_n;
    logic [IR_CNT_W-1:0] ir_cnt;
  } usca_st_t;

  usca_st_t st_reg;
  usca_st_t st_next;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic              wr_ok;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;
  logic              wr_lane0;
  logic              tx_cause;
  logic              rx_cause;
  logic              above;
  logic [FILL_W-1:0] thresh;
  logic              ir_burst;
  logic              fen_drop;

  // Bus front end
  usca_axil u_axil (
    .clk     (MCLK),
    .rst     (RESET),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Soft reset, one stretcher each for the bus-side and serial-side resets, both on MCLK
  usca_rst_sync u_ctrl_rst (
    .clk     (MCLK),
    .rst     (RESET),
    .arst    (st_reg.soft_req),
    .rst_out (CTRL_RESET)
  );

  usca_rst_sync u_ser_rst (
    .clk     (MCLK),
    .rst     (RESET),
    .arst    (st_reg.soft_req),
    .rst_out (SER_RESET)
  );

  // Address decode: every mapped register answers OKAY, anything else SLVERR
  assign wr_ok = (wr_addr == FIFO_CORE_SOFT_RESET_ADDR) || (wr_addr == REQUEST_TO_SEND_ALIAS_ADDR)
              || (wr_addr == BREAK_CONTROL_ALIAS_ADDR) || (wr_addr == DMA_SIGNAL_MODE_ALIAS_ADDR)
              || (wr_addr == LINE_OPTIONS_ADDR) || (wr_addr == ALIAS_STATUS_ADDR);
  assign wr_lane0 = wr_en && wr_strb[0];

  // Read mux; write-only and reserved bits return zero
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      FIFO_CORE_SOFT_RESET_ADDR: rd_data = '0;
      REQUEST_TO_SEND_ALIAS_ADDR: rd_data[ALIAS_BIT] = st_reg.rts;
      BREAK_CONTROL_ALIAS_ADDR: rd_data[ALIAS_BIT] = st_reg.brk;
      DMA_SIGNAL_MODE_ALIAS_ADDR: rd_data[ALIAS_BIT] = st_reg.dma_mode;
      LINE_OPTIONS_ADDR: begin
        rd_data[OPT_FIFO_EN_BIT] = st_reg.fifo_en;
        rd_data[OPT_AUTO_FLOW_BIT] = st_reg.auto_flow;
        rd_data[OPT_LOOPBACK_BIT] = st_reg.loopback;
        rd_data[OPT_IR_MODE_BIT] = st_reg.ir_mode;
        rd_data[OPT_RX_TRIG_LSB +: 2] = st_reg.rx_trig;
      end
      ALIAS_STATUS_ADDR: begin
        rd_data[STAT_LEVEL_LSB +: FILL_W] = RX_FILL_LEVEL;
        rd_data[STAT_ABOVE_BIT] = above;
        rd_data[STAT_CTRL_RST_BIT] = CTRL_RESET;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Receive threshold from the trigger selection
  always_comb begin
    case (st_reg.rx_trig)
      TRIG_ONE_CHAR: thresh = LEVEL_ONE;
      TRIG_QUARTER: thresh = LEVEL_QUARTER;
      TRIG_HALF: thresh = LEVEL_HALF;
      default: thresh = LEVEL_TWO_LESS;
    endcase
  end
  assign above = RX_FILL_LEVEL >= thresh;

  // Flush causes: a software request or FIFO enable falling
  // The fall is decoded from its own causes, so nothing loops back through the next state
  assign fen_drop = st_reg.fifo_en && (CTRL_RESET || (wr_lane0 && wr_addr == LINE_OPTIONS_ADDR
                 && !wr_data[OPT_FIFO_EN_BIT]));
  assign tx_cause = (wr_lane0 && wr_addr == FIFO_CORE_SOFT_RESET_ADDR && wr_data[TX_FLUSH_BIT])
                 || fen_drop;
  assign rx_cause = (wr_lane0 && wr_addr == FIFO_CORE_SOFT_RESET_ADDR && wr_data[RX_FLUSH_BIT])
                 || fen_drop;
  assign ir_burst = st_reg.ir_mode && st_reg.brk && !st_reg.loopback;

  // Next state of alias storage and pins
  always_comb begin
    st_next = st_reg;
    if (wr_lane0) begin
      case (wr_addr)
        REQUEST_TO_SEND_ALIAS_ADDR: st_next.rts = wr_data[ALIAS_BIT];
        BREAK_CONTROL_ALIAS_ADDR: st_next.brk = wr_data[ALIAS_BIT];
        DMA_SIGNAL_MODE_ALIAS_ADDR: st_next.dma_mode = wr_data[ALIAS_BIT];
        LINE_OPTIONS_ADDR: begin
          st_next.fifo_en = wr_data[OPT_FIFO_EN_BIT];
          st_next.auto_flow = wr_data[OPT_AUTO_FLOW_BIT];
          st_next.loopback = wr_data[OPT_LOOPBACK_BIT];
          st_next.ir_mode = wr_data[OPT_IR_MODE_BIT];
          st_next.rx_trig = wr_data[OPT_RX_TRIG_LSB +: 2];
        end
        default: st_next.rts = st_reg.rts;
      endcase
    end
    // A controller reset clears the control words the aliases stand for
    if (CTRL_RESET) begin
      st_next.rts = ALIAS_RESET;
      st_next.brk = ALIAS_RESET;
      st_next.dma_mode = ALIAS_RESET;
      st_next.fifo_en = ALIAS_RESET;
      st_next.auto_flow = ALIAS_RESET;
      st_next.loopback = ALIAS_RESET;
      st_next.ir_mode = ALIAS_RESET;
      st_next.rx_trig = TRIG_RESET;
    end
    // Flushes last one cycle, so software never writes zero to end them
    st_next.tx_flush = tx_cause;
    st_next.rx_flush = rx_cause;
    st_next.soft_req = wr_lane0 && wr_addr == FIFO_CORE_SOFT_RESET_ADDR
                    && wr_data[SOFT_RESET_BIT];
    // Receive pin synchroniser
    st_next.sin_meta = SIN;
    st_next.sin_sync = st_reg.sin_meta;
    // Request pin: loopback forces it idle, auto flow gates it on threshold
    if (st_reg.loopback) begin
      st_next.rts_n = 1'b1;
    end else if (st_reg.auto_flow && st_reg.fifo_en && above) begin
      st_next.rts_n = 1'b1;
    end else begin
      st_next.rts_n = !st_reg.rts;
    end
    st_next.loop_cts = st_reg.loopback && st_reg.rts;
    // Transmit line: break holds it low outside loopback
    if (st_reg.loopback) begin
      st_next.sout = 1'b1;
      st_next.rx_line = st_reg.brk ? 1'b0 : SER_TXD;
    end else begin
      st_next.sout = st_reg.brk ? 1'b0 : SER_TXD;
      st_next.rx_line = st_reg.sin_sync;
    end
    // Infrared output pulses low once per period for as long as break stands
    if (ir_burst) begin
      st_next.ir_cnt = (st_reg.ir_cnt == IR_CNT_W'(IR_PERIOD_CYC - 1)) ? '0
                     : st_reg.ir_cnt + 1'b1;
      st_next.ir_out_n = !(st_reg.ir_cnt < IR_CNT_W'(IR_PULSE_CYC));
    end else begin
      st_next.ir_cnt = '0;
      st_next.ir_out_n = 1'b1;
    end
    if (RESET) begin
      st_next = '0;
      st_next.rts_n = 1'b1;
      st_next.sout = 1'b1;
      st_next.rx_line = 1'b1;
      st_next.ir_out_n = 1'b1;
      st_next.sin_meta = 1'b1;
      st_next.sin_sync = 1'b1;
    end
  end

  // State register
  always_ff @(posedge MCLK) begin
    st_reg <= st_next;
  end

  // Outputs straight from state
  assign TX_FIFO_FLUSH = st_reg.tx_flush;
  assign RX_FIFO_FLUSH = st_reg.rx_flush;
  assign FIFO_ENABLE = st_reg.fifo_en;
  assign RX_TRIGGER = st_reg.rx_trig;
  assign DMA_MODE = st_reg.dma_mode;
  assign RX_LINE = st_reg.rx_line;
  assign LOOP_CTS = st_reg.loop_cts;
  assign SOUT = st_reg.sout;
  assign RTS_N = st_reg.rts_n;
  assign IR_OUT_N = st_reg.ir_out_n;

  // Checks
  localparam int IR_WIN = IR_PERIOD_CYC + 2;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_srr_wr(int b);
    wr_lane0 && wr_addr == FIFO_CORE_SOFT_RESET_ADDR && wr_data[b];
  endsequence
  sequence s_plain_rts;
    !st_reg.loopback && !st_reg.auto_flow && st_reg.rts && !CTRL_RESET;
  endsequence

  a_tx_flush_go: assert property (s_srr_wr(TX_FLUSH_BIT) |=> TX_FIFO_FLUSH)
    else $error("transmit flush missed");
  a_rx_flush_go: assert property (s_srr_wr(RX_FLUSH_BIT) |=> RX_FIFO_FLUSH)
    else $error("receive flush missed");
  a_flush_self_clear: assert property (TX_FIFO_FLUSH && !tx_cause |=> !TX_FIFO_FLUSH)
    else $error("transmit flush did not clear");
  a_soft_rst_seq: assert property (s_srr_wr(SOFT_RESET_BIT) |=> ##1 CTRL_RESET [*2])
    else $error("soft reset not asserted");
  a_both_domains: assert property (CTRL_RESET == SER_RESET)
    else $error("domain resets differ");
  a_rts_plain_low: assert property (s_plain_rts |=> !RTS_N)
    else $error("request pin not low");
  a_rts_auto_gate: assert property (!st_reg.loopback && st_reg.auto_flow && st_reg.fifo_en
                                    && above |=> RTS_N)
    else $error("auto flow did not raise request");
  a_rts_loop_idle: assert property (st_reg.loopback |=> RTS_N && LOOP_CTS == $past(st_reg.rts))
    else $error("loopback request wrong");
  a_brk_line_low: assert property (st_reg.brk && !st_reg.loopback |=> !SOUT)
    else $error("break not on line");
  a_brk_loop_rx: assert property (st_reg.brk && st_reg.loopback |=> !RX_LINE && SOUT)
    else $error("looped break wrong");
  a_ir_brk_pulse: assert property (ir_burst [*2] |-> ##[1:IR_WIN] !IR_OUT_N || !ir_burst)
    else $error("infrared break not pulsing");
  a_dma_mirror: assert property (wr_lane0 && wr_addr == DMA_SIGNAL_MODE_ALIAS_ADDR && !CTRL_RESET
                                 |=> DMA_MODE == $past(wr_data[ALIAS_BIT]))
    else $error("dma mode not mirrored");
  a_fen_fall_flush: assert property ($fell(FIFO_ENABLE) |-> TX_FIFO_FLUSH && RX_FIFO_FLUSH)
    else $error("fifo disable did not flush");
  a_srr_read_zero: assert property (S_AXI_ARADDR == FIFO_CORE_SOFT_RESET_ADDR |-> rd_data == '0)
    else $error("soft reset register read nonzero");
endmodule

/* File: verification/usca_modem.sv */
// Far-end serial device model on the request and receive lines.
// Assumes it shares MCLK with the block; the idle line is the high mark.
`timescale 1ns/1ns
module usca_modem (
  // Clock
  input  wire logic clk,
  // Line
  input  wire logic rts_n,
  output logic      sin
);
  // Sends a steady space only while asked, so a lost request shows on the receive line
  always_ff @(posedge clk) begin
    sin <= rts_n;
  end
endmodule

/* File: verification/usca_top_tb.sv */
// Self-checking bench for the shadow control aliases over AXI4-Lite.
// Assumes the package constants and a far-end model on the request pin.
`timescale 1ns/1ns
module usca_top_tb;
  import usca_pkg::*;
  logic        clk, rst, awv, wv, br, arv, rr;
  logic [31:0] awa, wd, ara;
  logic [4:0]  fill;
  wire logic   awr, wrd, bv, arr, rv, txf, rxf, fen, dma, rxl, lcts;
  wire logic   crst, srst, sin, sout, rts_n, ir_n;
  wire logic [1:0]  bresp, rresp, trig;
  wire logic [31:0] rdata;
  int          fails, n_compared, txc, rxc, irc;

  usca_top usca_top_inst (.MCLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .SER_TXD(1'h1),
    .RX_FILL_LEVEL(fill), .TX_FIFO_FLUSH(txf), .RX_FIFO_FLUSH(rxf), .FIFO_ENABLE(fen),
    .RX_TRIGGER(trig), .DMA_MODE(dma), .RX_LINE(rxl), .LOOP_CTS(lcts), .CTRL_RESET(crst),
    .SER_RESET(srst), .SIN(sin), .SOUT(sout), .RTS_N(rts_n), .IR_OUT_N(ir_n));
  usca_modem usca_modem_inst (.clk(clk), .rts_n(rts_n), .sin(sin));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Pulse counters; scenarios diff them, so no reset race with the tasks
  always @(posedge clk) begin
    txc <= txc + int'(txf === 1'h1);
    rxc <= rxc + int'(rxf === 1'h1);
    irc <= irc + int'(ir_n === 1'h0);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus cycles: the leading edge keeps a released valid from being raised in the same step
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrd) wv <= 1'h0;
      if (bv === 1'h1) begin
        br <= 1'h0;
        chk(bresp, e);
        return;
      end
    end
    fails++;
    tally_and_finish();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
      if (rv === 1'h1) begin
        rr <= 1'h0;
        chk(rdata, e);
        chk(rresp, RESP_OKAY);
        return;
      end
    end
    fails++;
    tally_and_finish();
  endtask

  task automatic t_flush;
    int t0, r0;
    t0 = txc;
    r0 = rxc;
    wr(FIFO_CORE_SOFT_RESET_ADDR, 32'h0000_0004, RESP_OKAY);
    tk(4);
    chk(txc - t0, 1);
    chk(rxc - r0, 0);
    wr(FIFO_CORE_SOFT_RESET_ADDR, 32'h0000_0002, RESP_OKAY);
    tk(4);
    chk(rxc - r0, 1);
    rd(FIFO_CORE_SOFT_RESET_ADDR, 32'h0000_0000);
  endtask
  task automatic t_rts;
    int t0, r0;
    wr(REQUEST_TO_SEND_ALIAS_ADDR, 32'hFFFF_FFFF, RESP_OKAY);
    rd(REQUEST_TO_SEND_ALIAS_ADDR, 32'h0000_0001);
    tk(6);
    chk(rts_n, 1'h0);
    chk(rxl, 1'h0);
    wr(LINE_OPTIONS_ADDR, 32'h0000_0013, RESP_OKAY);
    tk(3);
    chk({fen, trig}, 3'h5);
    fill <= 5'h03;
    tk(3);
    chk(rts_n, 1'h0);
    fill <= 5'h04;
    tk(3);
    chk(rts_n, 1'h1);
    rd(ALIAS_STATUS_ADDR, 32'h0000_0104);
    fill <= 5'h00;
    t0 = txc;
    r0 = rxc;
    wr(LINE_OPTIONS_ADDR, 32'h0000_0004, RESP_OKAY);
    tk(3);
    chk(rts_n, 1'h1);
    chk(lcts, 1'h1);
    chk(fen, 1'h0);
    chk(txc - t0, 1);
    chk(rxc - r0, 1);
  endtask
  task automatic t_brk;
    int t0;
    wr(BREAK_CONTROL_ALIAS_ADDR, 32'h0000_0001, RESP_OKAY);
    rd(BREAK_CONTROL_ALIAS_ADDR, 32'h0000_0001);
    tk(5);
    chk(sout, 1'h1);
    chk(rxl, 1'h0);
    wr(LINE_OPTIONS_ADDR, 32'h0000_0000, RESP_OKAY);
    tk(3);
    chk(sout, 1'h0);
    wr(LINE_OPTIONS_ADDR, 32'h0000_0008, RESP_OKAY);
    tk(3);
    t0 = irc;
    tk(IR_PERIOD_CYC);
    chk(irc - t0, IR_PULSE_CYC);
  endtask
  task automatic t_dma;
    wr(DMA_SIGNAL_MODE_ALIAS_ADDR, 32'h0000_0001, RESP_OKAY);
    rd(DMA_SIGNAL_MODE_ALIAS_ADDR, 32'h0000_0001);
    chk(dma, 1'h1);
    wr(DMA_SIGNAL_MODE_ALIAS_ADDR, 32'h0000_0000, RESP_OKAY);
    tk(2);
    chk(dma, 1'h0);
  endtask
  task automatic t_srst;
    wr(FIFO_CORE_SOFT_RESET_ADDR, 32'h0000_0001, RESP_OKAY);
    chk({crst, srst}, 2'h3);
    tk(6);
    chk({crst, srst}, 2'h0);
    rd(BREAK_CONTROL_ALIAS_ADDR, 32'h0000_0000);
  endtask

  // Main sequence: hold reset 20 cycles, then the scenarios
  initial begin
    rst = 1'h1;
    {awv, wv, br, arv, rr} = 5'h00;
    {awa, wd, ara} = '0;
    fill = 5'h00;
    {fails, n_compared, txc, rxc, irc} = '0;
    tk(20);
    rst <= 1'h0;
    chk(rts_n, 1'h1);
    rd(REQUEST_TO_SEND_ALIAS_ADDR, 32'h0000_0000);
    wr(32'h5000_1100, 32'h0000_0001, RESP_SLVERR);
    t_flush();
    t_rts();
    t_brk();
    t_dma();
    t_srst();
    tally_and_finish();
  end
endmodule
